/* core/mvr_pkg.sv */
// Package: constants and types for the move-and-return execution block
`default_nettype none
package mvr_pkg;
  localparam int PC_W = 15;
  localparam int FSR_W = 16;
  localparam int STK_DEPTH = 16;
  localparam logic [4:0] BANK_SEL_RST = 5'h00;
  localparam logic [6:0] PC_LATCH_RST = 7'h00;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'hFF;
  localparam logic [15:0] FSR_RST = 16'h0000;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam int IRQ_EN_BIT = 7;
  localparam int RET_CYCLES = 2;
  // Operation selector decoded upstream from the instruction word
  typedef enum logic [3:0] {
    MVR_OP_NOP, MVR_OP_LDBANK, MVR_OP_LDPAGE, MVR_OP_LDW, MVR_OP_STF,
    MVR_OP_STIND, MVR_OP_STREL, MVR_OP_OPTION, MVR_OP_SRESET, MVR_OP_RETIRQ
  } mvr_op_t;
  typedef enum logic [1:0] {
    MVR_MM_PREINC = 2'h0, MVR_MM_PREDEC = 2'h1, MVR_MM_POSTINC = 2'h2, MVR_MM_POSTDEC = 2'h3
  } mvr_mm_t;
  typedef enum {MVR_ST_EXEC, MVR_ST_RET2} mvr_state_t;
endpackage : mvr_pkg
`default_nettype wire

/* core/mvr_stack_if.sv */
// Interface: push/pop port between the executor and its return stack
`default_nettype none
interface mvr_stack_if;
  import mvr_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_addr;
  logic empty;
  modport ctrl (output push, output pop, output push_addr, input top_addr, input empty);
  modport mem (input push, input pop, input push_addr, output top_addr, output empty);
endinterface : mvr_stack_if
`default_nettype wire

/* core/mvr_stack.sv */
// Hardware return stack with registered top-of-stack read
`default_nettype none
module mvr_stack
  import mvr_pkg::*;
#(
  parameter int DEPTH = STK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  mvr_stack_if.mem st
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two >= 2");
  end
  logic [PC_W-1:0] mem_q [DEPTH];
  logic [PW-1:0] sp_reg;
  logic [PW:0] cnt_reg;
  logic [PC_W-1:0] top_reg;
  wire logic [PW-1:0] sp_next = st.push ? sp_reg + 1'b1 : st.pop ? sp_reg - 1'b1 : sp_reg;
  // Overflow wraps, as a circular stack does; contents are not reset
  always_ff @(posedge clk_sys) begin
    if (st.push) begin
      mem_q[sp_reg + 1'b1] <= st.push_addr;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sp_reg <= '0;
      cnt_reg <= '0;
      top_reg <= '0;
    end else begin
      sp_reg <= sp_next;
      if (st.push && cnt_reg != (PW+1)'(DEPTH)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (st.pop && cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
      top_reg <= st.push ? st.push_addr : mem_q[sp_next];
    end
  end
  assign st.top_addr = top_reg;
  assign st.empty = (cnt_reg == '0);
endmodule : mvr_stack
`default_nettype wire

/* core/mvr_exec.sv */
// Execution unit for literal loads, W stores, indirect stores, NOP, soft reset and return
//
// Function
// RULE1: load_bank_literal puts operand into bank select; the code loads only operand bits 3:0 and holds bank select bit 4 at 0
// RULE2: load_page_latch_literal loads seven-bit PC latch
// RULE3: load_w_literal puts eight-bit literal into W
// RULE4: store_w_to_file writes W to file, one cycle
// RULE5: store_w_indirect writes W via chosen pointer
// RULE6: Mode field picks pre/post increment/decrement
// RULE7: Relative form addresses pointer plus offset, unchanged
// RULE8: Pointers wrap modulo sixteen bits
// RULE9: Pointer adjust leaves status bits alone
// RULE10: Indirect port redirects to pointer's address
// RULE11: Option load copies W, single cycle
// RULE12: Soft reset resets device, clears flag
// RULE13: Return pops stack into PC, two cycles
// RULE14: Return sets global interrupt enable bit
// RULE15: NOP only advances the program counter
// RULE16: Loads and indirect store take one cycle
`default_nettype none
module mvr_exec
  import mvr_pkg::*;
#(
  parameter int STACK_DEPTH = STK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  // Decoded instruction
  input wire logic instr_valid,
  input wire mvr_op_t instr_op,
  input wire logic [7:0] instr_lit,
  input wire logic [6:0] instr_faddr,
  input wire logic instr_fsr_sel,
  input wire logic [1:0] instr_mm,
  input wire logic [5:0] instr_offset,
  // Call support from neighbouring logic
  input wire logic call_push,
  input wire logic irq_clear_gie,
  // Reset cause and status
  input wire logic soft_reset_flag_set,
  // Architectural state
  output logic [PC_W-1:0] pc,
  output logic [4:0] bank_select_reg,
  output logic [6:0] pc_high_latch,
  output logic [7:0] w_reg,
  output logic [7:0] option_reg,
  output logic [15:0] fsr0,
  output logic [15:0] fsr1,
  output logic global_irq_enable,
  output logic soft_reset_flag,
  output logic instr_ready,
  output logic dev_reset_req,
  // Data memory write port
  output logic dmem_we,
  output logic [15:0] dmem_addr,
  output logic [7:0] dmem_wdata
);
  // Stack pointer arithmetic wraps, so only powers of two are served
  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("STACK_DEPTH must be a power of two >= 2");
  end
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] mvr_adj(input logic [15:0] p, input logic dec);
    mvr_adj = dec ? p - 16'h0001 : p + 16'h0001; // RULE8
  endfunction : mvr_adj
  //////////////////////////////////////////////////////////////////////////////
  mvr_stack_if stk ();
  mvr_stack #(.DEPTH(STACK_DEPTH)) u_stack (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .st(stk)
  );
  mvr_state_t state_reg, state_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [4:0] bank_reg;
  logic [6:0] pcl_reg;
  logic [7:0] w_q, opt_reg;
  logic [15:0] fsr_reg [2];
  logic irq_en_reg, sr_flag_reg, rst_req_reg, rdy_reg;
  logic we_reg;
  logic [15:0] addr_reg;
  logic [7:0] wd_reg;
  // Soft reset re-enters reset on the next edge, like a hardware reset
  logic sw_rst_reg;
  wire logic rst_all = sw_rst_reg;
  // Ready gates issue; without it a request waiting out reset runs twice
  wire logic go = instr_valid && rdy_reg && state_reg == MVR_ST_EXEC;
  wire logic is_op_sreset = go && instr_op == MVR_OP_SRESET;
  wire logic is_op_retirq = go && instr_op == MVR_OP_RETIRQ;
  wire logic is_op_ind = go && instr_op == MVR_OP_STIND;
  wire logic is_op_rel = go && instr_op == MVR_OP_STREL;
  wire logic [15:0] fsr_cur = fsr_reg[instr_fsr_sel];
  wire logic mm_dec = instr_mm[0];
  wire logic mm_post = instr_mm[1];
  wire logic [15:0] fsr_adj = mvr_adj(fsr_cur, mm_dec); // RULE6
  wire logic [15:0] ind_addr = mm_post ? fsr_cur : fsr_adj; // RULE6 RULE10
  wire logic [15:0] rel_addr = fsr_cur + {{10{instr_offset[5]}}, instr_offset}; // RULE7 RULE8
  wire logic [PC_W-1:0] pc_inc = pc_reg + 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  assign stk.push = call_push && go;
  assign stk.push_addr = pc_inc;
  assign stk.pop = is_op_retirq; // RULE13
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    unique case (state_reg)
      MVR_ST_EXEC: begin
        if (go) begin
          if (instr_op == MVR_OP_RETIRQ) begin
            // Top is read before the pop edge replaces it
            state_next = MVR_ST_RET2; // RULE13
            pc_next = stk.top_addr; // RULE13
          end else begin
            pc_next = pc_inc; // RULE15 RULE16
          end
        end
      end
      MVR_ST_RET2: begin
        // Second cycle of the return only retires
        state_next = MVR_ST_EXEC; // RULE13
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= MVR_ST_EXEC;
      pc_reg <= PC_RST;
      rdy_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else if (rst_all) begin
      state_reg <= MVR_ST_EXEC;
      pc_reg <= PC_RST; // RULE12
      rdy_reg <= 1'b0;
      sw_rst_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      // No issue in the cycle in which the soft reset lands
      rdy_reg <= (state_next == MVR_ST_EXEC) && !is_op_sreset;
      sw_rst_reg <= is_op_sreset; // RULE12
      rst_req_reg <= is_op_sreset; // RULE12
    end
  end
  // Flag survives the soft reset it records; cleared by the instruction itself
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sr_flag_reg <= 1'b1;
    end else if (is_op_sreset) begin
      sr_flag_reg <= 1'b0; // RULE12
    end else if (soft_reset_flag_set) begin
      sr_flag_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= BANK_SEL_RST;
      pcl_reg <= PC_LATCH_RST;
      w_q <= W_RST;
      opt_reg <= OPT_RST;
      irq_en_reg <= 1'b0;
    end else if (rst_all) begin
      bank_reg <= BANK_SEL_RST;
      pcl_reg <= PC_LATCH_RST;
      w_q <= W_RST;
      opt_reg <= OPT_RST;
      irq_en_reg <= 1'b0;
    end else begin
      if (go && instr_op == MVR_OP_LDBANK) bank_reg <= {1'b0, instr_lit[3:0]}; // RULE1
      if (go && instr_op == MVR_OP_LDPAGE) pcl_reg <= instr_lit[6:0]; // RULE2
      if (go && instr_op == MVR_OP_LDW) w_q <= instr_lit; // RULE3
      if (go && instr_op == MVR_OP_OPTION) opt_reg <= w_q; // RULE11
      // Return beats a same-cycle clear, so the pop re-enables interrupts
      if (stk.pop) begin
        irq_en_reg <= 1'b1; // RULE14
      end else if (irq_clear_gie) begin
        irq_en_reg <= 1'b0;
      end
    end
  end
  // Pointer updates touch no status bit: this block has no status path
  for (genvar g = 0; g < 2; g++) begin : g_fsr
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        fsr_reg[g] <= FSR_RST;
      end else if (rst_all) begin
        fsr_reg[g] <= FSR_RST;
      end else if (is_op_ind && instr_fsr_sel == g[0]) begin
        fsr_reg[g] <= fsr_adj; // RULE6 RULE9
      end
    end
  end
  // Strobe is registered; address and data ride with it for one cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      we_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wd_reg <= 8'h00;
    end else begin
      we_reg <= !rst_all && (is_op_ind || is_op_rel || (go && instr_op == MVR_OP_STF));
      addr_reg <= is_op_ind ? ind_addr : is_op_rel ? rel_addr : {9'h000, instr_faddr}; // RULE4 RULE5 RULE7
      wd_reg <= w_q; // RULE4 RULE5
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Every output below is a flip-flop
  assign pc = pc_reg;
  assign bank_select_reg = bank_reg;
  assign pc_high_latch = pcl_reg;
  assign w_reg = w_q;
  assign option_reg = opt_reg;
  assign fsr0 = fsr_reg[0];
  assign fsr1 = fsr_reg[1];
  assign global_irq_enable = irq_en_reg;
  assign soft_reset_flag = sr_flag_reg;
  assign instr_ready = rdy_reg;
  assign dev_reset_req = rst_req_reg;
  assign dmem_we = we_reg;
  assign dmem_addr = addr_reg;
  assign dmem_wdata = wd_reg;
endmodule : mvr_exec
`default_nettype wire

/* tb/mvr_exec_properties.sv */
// Checker: port-level properties of the move-and-return executor
`default_nettype none
module mvr_exec_properties
  import mvr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire mvr_op_t instr_op,
  input wire logic [7:0] instr_lit,
  input wire logic [6:0] instr_faddr,
  input wire logic instr_fsr_sel,
  input wire logic [1:0] instr_mm,
  input wire logic [5:0] instr_offset,
  input wire logic [PC_W-1:0] pc,
  input wire logic [4:0] bank_select_reg,
  input wire logic [6:0] pc_high_latch,
  input wire logic [7:0] w_reg,
  input wire logic [7:0] option_reg,
  input wire logic [15:0] fsr0,
  input wire logic [15:0] fsr1,
  input wire logic global_irq_enable,
  input wire logic soft_reset_flag,
  input wire logic instr_ready,
  input wire logic dev_reset_req,
  input wire logic dmem_we,
  input wire logic [15:0] dmem_addr,
  input wire logic [7:0] dmem_wdata
);
  wire logic tk = instr_valid && instr_ready;
  wire logic [15:0] adj = instr_mm[0] ? fsr0 - 16'h0001 : fsr0 + 16'h0001;
  wire logic [15:0] ea = instr_mm[1] ? fsr0 : adj;
  wire logic [15:0] fp = instr_fsr_sel ? fsr1 : fsr0;
  wire logic [15:0] rel = fp + {{10{instr_offset[5]}}, instr_offset};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence ret_s;
    !instr_ready && global_irq_enable ##1 instr_ready;
  endsequence
  sequence srst_s;
    !soft_reset_flag && dev_reset_req ##1 !instr_ready && w_reg == W_RST && pc == PC_RST;
  endsequence
  AST_LDBANK: assert property (tk && instr_op == MVR_OP_LDBANK |=>
    bank_select_reg == {1'b0, $past(instr_lit[3:0])}) else $error("bank load wrong");
  AST_LDPAGE: assert property (tk && instr_op == MVR_OP_LDPAGE |=>
    pc_high_latch == $past(instr_lit[6:0])) else $error("page latch load wrong");
  AST_LDW: assert property (tk && instr_op == MVR_OP_LDW |=>
    w_reg == $past(instr_lit)) else $error("W load wrong");
  AST_STF: assert property (tk && instr_op == MVR_OP_STF |=> dmem_we &&
    dmem_addr[6:0] == $past(instr_faddr) && dmem_wdata == $past(w_reg)) else $error("file store");
  AST_STIND: assert property (tk && instr_op == MVR_OP_STIND && !instr_fsr_sel |=>
    dmem_we && fsr0 == $past(adj) && dmem_addr == $past(ea)) else $error("indirect store");
  AST_STREL: assert property (tk && instr_op == MVR_OP_STREL |=>
    dmem_addr == $past(rel) && $stable(fsr0) && $stable(fsr1)) else $error("relative store");
  AST_OPTION: assert property (tk && instr_op == MVR_OP_OPTION |=>
    option_reg == $past(w_reg)) else $error("option load wrong");
  AST_SRESET: assert property (tk && instr_op == MVR_OP_SRESET |=>
    srst_s) else $error("soft reset sequence wrong");
  AST_RETIRQ: assert property (tk && instr_op == MVR_OP_RETIRQ |=>
    ret_s) else $error("return sequence wrong");
  AST_NOP: assert property (tk && instr_op == MVR_OP_NOP |=>
    $stable(w_reg) && $stable(option_reg) && $stable(fsr0)) else $error("nop changed state");
  AST_STEP: assert property (tk && instr_op <= MVR_OP_OPTION |=>
    pc == $past(pc) + 15'h0001 && instr_ready) else $error("single cycle step");
endmodule : mvr_exec_properties
bind mvr_exec mvr_exec_properties u_props (.*);
`default_nettype wire

/* tb/cpu_move_and_return_instr_bench.sv */
// Testbench: directed scenarios for the move-and-return executor
`default_nettype none
module cpu_move_and_return_instr_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mvr_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, instr_valid = 1'b0, instr_fsr_sel = 1'b0;
  logic call_push = 1'b0, irq_clear_gie = 1'b0, soft_reset_flag_set = 1'b0;
  mvr_op_t instr_op = MVR_OP_NOP;
  logic [7:0] instr_lit = 8'h00;
  logic [6:0] instr_faddr = 7'h00;
  logic [1:0] instr_mm = 2'h0;
  logic [5:0] instr_offset = 6'h00;
  logic [PC_W-1:0] pc, p;
  logic [4:0] bank_select_reg;
  logic [6:0] pc_high_latch;
  logic [7:0] w_reg, option_reg, dmem_wdata;
  logic [15:0] fsr0, fsr1, dmem_addr;
  logic global_irq_enable, soft_reset_flag, instr_ready, dev_reset_req, dmem_we;
  int error_cnt = 0, num_checks = 0;
  mvr_exec uut (.*);
  initial forever #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Leaves valid high so callers can issue back to back
  task automatic step(input mvr_op_t o, input logic [7:0] l);
    int n;
    n = 0;
    instr_op = o;
    instr_lit = l;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 20) begin
        chk(1'b0, "ready timeout");
        end_sim;
      end
    end
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  ////////////////////////////////////////////////////////////////////////
  task automatic t_lit;
    step(MVR_OP_LDBANK, 8'h0F);
    chk(bank_select_reg === 5'h0F, "bank");
    step(MVR_OP_LDPAGE, 8'h7F);
    chk(pc_high_latch === 7'h7F, "page");
    step(MVR_OP_LDW, 8'hA5);
    chk(w_reg === 8'hA5 && pc === 15'h0003, "w and pc");
    instr_faddr = 7'h7F;
    step(MVR_OP_STF, 8'h00);
    chk(dmem_we === 1'b1 && dmem_wdata === 8'hA5 && dmem_addr[6:0] === 7'h7F, "stf");
    step(MVR_OP_OPTION, 8'h00);
    chk(option_reg === 8'hA5 && dmem_we === 1'b0, "option");
  endtask : t_lit
  // Walks all four modes on both pointers; wraps at both ends
  task automatic t_ind;
    logic [15:0] fp [2];
    logic [15:0] nv, ea;
    fp = '{16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      instr_fsr_sel = i[0];
      instr_mm = 2'h3 - i[2:1];
      nv = instr_mm[0] ? fp[i[0]] - 16'h0001 : fp[i[0]] + 16'h0001;
      ea = instr_mm[1] ? fp[i[0]] : nv;
      fp[i[0]] = nv;
      step(MVR_OP_STIND, 8'h00);
      chk(dmem_we === 1'b1 && dmem_addr === ea && dmem_wdata === 8'hA5, "ind");
      chk(fsr0 === fp[0] && fsr1 === fp[1], "pointer");
    end
    instr_offset = 6'h20;
    step(MVR_OP_STREL, 8'h00);
    chk(dmem_addr === 16'hFFE0 && fsr1 === 16'h0000, "rel low");
    instr_offset = 6'h1F;
    step(MVR_OP_STREL, 8'h00);
    chk(dmem_addr === 16'h001F && fsr1 === 16'h0000, "rel high");
  endtask : t_ind
  task automatic t_ret;
    p = pc;
    call_push = 1'b1;
    step(MVR_OP_NOP, 8'h00);
    call_push = 1'b0;
    chk(pc === p + 15'h0001 && w_reg === 8'hA5 && fsr0 === 16'h0000, "nop");
    step(MVR_OP_NOP, 8'h00);
    step(MVR_OP_RETIRQ, 8'h00);
    instr_valid = 1'b0;
    chk(instr_ready === 1'b0 && global_irq_enable === 1'b1, "ret gie");
    tick;
    chk(pc === p + 15'h0001 && instr_ready === 1'b1, "ret pc");
    irq_clear_gie = 1'b1;
    tick;
    irq_clear_gie = 1'b0;
    chk(global_irq_enable === 1'b0, "gie clear");
  endtask : t_ret
  task automatic t_srst;
    step(MVR_OP_SRESET, 8'h00);
    instr_valid = 1'b0;
    chk(soft_reset_flag === 1'b0 && dev_reset_req === 1'b1, "sreset req");
    tick;
    chk(w_reg === W_RST && option_reg === OPT_RST && pc === PC_RST, "sreset state");
    soft_reset_flag_set = 1'b1;
    tick;
    soft_reset_flag_set = 1'b0;
    chk(soft_reset_flag === 1'b1 && dev_reset_req === 1'b0, "flag set");
  endtask : t_srst
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    chk(option_reg === OPT_RST && soft_reset_flag === 1'b1 && instr_ready === 1'b0, "rst");
    resetn = 1'b1;
    t_lit;
    t_ind;
    t_ret;
    t_srst;
    end_sim;
  end
endmodule : cpu_move_and_return_instr_bench
`default_nettype wire
